// *** include/fli_pkg.sv ***
package fli_pkg;

    // ************************************************
    // timebase
    // ************************************************
    localparam int CLK_KHZ = 200000;
    localparam int TICK_MS = 50;
    localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
    localparam int PRESCALE_W = 24;
    localparam int FLASH_MS = 200;
    localparam int DARK_MS = 1000;
    localparam int FLASH_TICKS = FLASH_MS / TICK_MS;
    localparam int DARK_TICKS = DARK_MS / TICK_MS;
    localparam int BLINK_PERIOD = 2 * FLASH_TICKS;
    localparam int SINGLE_PERIOD = FLASH_TICKS + DARK_TICKS;
    localparam int DOUBLE_PERIOD = 3 * FLASH_TICKS + DARK_TICKS;
    localparam int PHASE_PERIOD = 96;
    localparam int PHASE_W = 7;

    // ************************************************
    // register map
    // ************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ERR_STATUS = 8'h04;
    localparam logic [7:0] OFF_ERR_MASK = 8'h08;
    localparam logic [7:0] OFF_LINK_STATUS = 8'h0c;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    localparam int CTRL_NODE_LSB = 0;
    localparam int NODE_W = 3;
    localparam int CTRL_FWDL_BIT = 4;
    localparam int CTRL_CHANGE_LSB = 8;
    localparam int CTRL_W = 16;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'hff17;
    localparam logic [7:0] CHANGE_ERR = 8'h01;

    localparam logic [2:0] NODE_BOOTING = 3'h0;
    localparam logic [2:0] NODE_INIT = 3'h1;
    localparam logic [2:0] NODE_PREPARING = 3'h2;
    localparam logic [2:0] NODE_FW_LOADER = 3'h3;
    localparam logic [2:0] NODE_INPUTS_ONLY = 3'h4;
    localparam logic [2:0] NODE_RUNNING = 3'h5;

    localparam int ERR_N = 5;
    localparam int ERR_PROC_WDG = 0;
    localparam int ERR_CONFIG = 1;
    localparam int ERR_BOOT = 2;
    localparam int ERR_AUTO_CHANGE = 3;
    localparam int ERR_APP_WDG = 4;
    localparam logic [4:0] ERR_RESET = 5'h00;

    localparam int LS_LINK_LSB = 0;
    localparam int LS_ACT_LSB = 2;
    localparam int LS_LED_LSB = 4;
    localparam int LS_RUN_BIT = 6;
    localparam int LS_RED_BIT = 7;
    localparam int LS_SDA_BIT = 8;
    localparam int LS_PHASE_LSB = 16;

    // ************************************************
    // types
    // ************************************************
    typedef enum logic [5:0] {
        PAT_OFF = 6'b000001,
        PAT_ON = 6'b000010,
        PAT_FLICKER = 6'b000100,
        PAT_BLINK = 6'b001000,
        PAT_SINGLE = 6'b010000,
        PAT_DOUBLE = 6'b100000
    } fli_pattern_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } fli_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } fli_ahb_rsp_t;

    typedef struct packed {
        logic [1:0] link_s1;
        logic [1:0] link_s2;
        logic [1:0] act_s1;
        logic [1:0] act_s2;
        logic [ERR_N-1:0] evt_s1;
        logic [ERR_N-1:0] evt_s2;
        logic [ERR_N-1:0] evt_d;
        logic sda_s1;
        logic sda_s2;
        logic [PRESCALE_W-1:0] prescale;
        logic [PHASE_W-1:0] phase;
        logic [1:0] act_seen;
        logic [1:0] act_show;
        logic [CTRL_W-1:0] ctrl;
        logic [ERR_N-1:0] err_stat;
        logic [ERR_N-1:0] err_mask;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic [1:0] link_led;
        logic run_led;
        logic red_on;
        logic irq;
    } fli_state_t;

endpackage

// *** rtl/fli_pattern.sv ***
`timescale 1ns/1ps
`default_nettype none

module fli_pattern (
    input wire fli_pkg::fli_pattern_t pattern,
    input wire logic [fli_pkg::PHASE_W-1:0] phase,
    output logic lit
);

    // ************************************************
    // phase to lamp decode
    // ************************************************
    // the phase period is a common multiple of every pattern period,
    // so each pattern restarts cleanly when the phase wraps
    logic [fli_pkg::PHASE_W-1:0] p_blink;
    logic [fli_pkg::PHASE_W-1:0] p_single;
    logic [fli_pkg::PHASE_W-1:0] p_double;

    always_comb begin
        p_blink = phase % fli_pkg::PHASE_W'(fli_pkg::BLINK_PERIOD);
        p_single = phase % fli_pkg::PHASE_W'(fli_pkg::SINGLE_PERIOD);
        p_double = phase % fli_pkg::PHASE_W'(fli_pkg::DOUBLE_PERIOD);
        lit = 1'b0;
        unique case (pattern)
            fli_pkg::PAT_OFF: lit = 1'b0;
            fli_pkg::PAT_ON: lit = 1'b1;
            fli_pkg::PAT_FLICKER: lit = ~phase[0];
            fli_pkg::PAT_BLINK: begin
                lit = p_blink < fli_pkg::PHASE_W'(fli_pkg::FLASH_TICKS);
            end
            fli_pkg::PAT_SINGLE: begin
                lit = p_single < fli_pkg::PHASE_W'(fli_pkg::FLASH_TICKS);
            end
            fli_pkg::PAT_DOUBLE: begin
                lit = (p_double < fli_pkg::PHASE_W'(fli_pkg::FLASH_TICKS)) ||
                      ((p_double >= fli_pkg::PHASE_W'(2 * fli_pkg::FLASH_TICKS))
                      && (p_double <
                      fli_pkg::PHASE_W'(3 * fli_pkg::FLASH_TICKS)));
            end
            default: lit = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// *** rtl/fli_indicator.sv ***
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - link led steady on for valid idle link, off when link invalid
// - valid link with passing frames flickers the link led
// - inbound and outbound ports each have their own link led
// - running node state holds the run led steadily on
// - preparing state blinks run led 200 ms on, 200 ms off
// - inputs-only state: single 200 ms flash then 1000 ms dark
// - booting, firmware loader or download flickers run led 50/50 ms
// - init state keeps the run led off
// - process data watchdog timeout holds red led steadily on
// - configuration error blinks red 200 ms on, 200 ms off
// - boot error in init with change flag 0x01 flickers red
// - autonomous state change with change flag 0x01 single-flashes red
// - application watchdog timeout double-flashes red, then 1000 ms dark
// - red led is driven through the i2c data line

module fli_indicator #(
    parameter int TICK_CYCLES = fli_pkg::TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire fli_pkg::fli_ahb_req_t ahb_req,
    output fli_pkg::fli_ahb_rsp_t ahb_rsp,
    input wire logic inbound_port_link,
    input wire logic inbound_port_activity,
    input wire logic outbound_port_link,
    input wire logic outbound_port_activity,
    input wire logic process_data_interface_wdg_timeout,
    input wire logic config_error,
    input wire logic boot_error,
    input wire logic autonomous_change,
    input wire logic app_wdg_timeout,
    output logic inbound_port_link_led,
    output logic outbound_port_link_led,
    output logic run_led,
    input wire logic err_sda_i,
    output logic err_sda_o,
    output logic err_sda_oe_n,
    output logic irq
);

    // ************************************************
    // register select
    // ************************************************
    // only the low address byte is decoded, so the map aliases
    // across the slave's whole hsel window
    function automatic logic [3:0] reg_sel(input logic [7:0] addr);
        logic [3:0] sel;
        sel = 4'h0;
        unique case (addr)
            fli_pkg::OFF_CTRL: sel = 4'h1;
            fli_pkg::OFF_ERR_STATUS: sel = 4'h2;
            fli_pkg::OFF_ERR_MASK: sel = 4'h4;
            fli_pkg::OFF_LINK_STATUS: sel = 4'h8;
            default: sel = 4'h0;
        endcase
        return sel;
    endfunction

    // ************************************************
    // state
    // ************************************************
    fli_pkg::fli_state_t st_ff;
    fli_pkg::fli_state_t nxt_st;
    fli_pkg::fli_pattern_t run_pat;
    fli_pkg::fli_pattern_t red_pat;
    logic run_lit;
    logic red_lit;

    logic tick;
    logic addr_take;
    logic [3:0] rd_sel;
    logic [3:0] wr_sel;
    logic [31:0] rd_word;
    logic [fli_pkg::ERR_N-1:0] evt_rise;
    logic [fli_pkg::ERR_N-1:0] evt_set;
    logic [fli_pkg::ERR_N-1:0] w1c;
    logic [fli_pkg::NODE_W-1:0] node;
    logic [7:0] change_flag;
    logic change_err;

    // ************************************************
    // lamp patterns
    // ************************************************
    fli_pattern u_run_pattern (
        .pattern(run_pat),
        .phase(st_ff.phase),
        .lit(run_lit)
    );

    fli_pattern u_red_pattern (
        .pattern(red_pat),
        .phase(st_ff.phase),
        .lit(red_lit)
    );

    // ************************************************
    // node state to run pattern
    // ************************************************
    always_comb begin
        node = st_ff.ctrl[fli_pkg::CTRL_NODE_LSB +: fli_pkg::NODE_W];
        change_flag = st_ff.ctrl[fli_pkg::CTRL_CHANGE_LSB +: 8];
        change_err = change_flag == fli_pkg::CHANGE_ERR;
        run_pat = fli_pkg::PAT_OFF;
        if (st_ff.ctrl[fli_pkg::CTRL_FWDL_BIT]) begin
            run_pat = fli_pkg::PAT_FLICKER;
        end else begin
            unique case (node)
                fli_pkg::NODE_RUNNING: run_pat = fli_pkg::PAT_ON;
                fli_pkg::NODE_PREPARING: run_pat = fli_pkg::PAT_BLINK;
                fli_pkg::NODE_INPUTS_ONLY: begin
                    run_pat = fli_pkg::PAT_SINGLE;
                end
                fli_pkg::NODE_INIT: run_pat = fli_pkg::PAT_OFF;
                fli_pkg::NODE_BOOTING: run_pat = fli_pkg::PAT_FLICKER;
                fli_pkg::NODE_FW_LOADER: run_pat = fli_pkg::PAT_FLICKER;
                default: run_pat = fli_pkg::PAT_OFF;
            endcase
        end
    end

    // ************************************************
    // pending errors to red pattern
    // ************************************************
    // the red lamp follows the sticky status, not the mask, so masking
    // an interrupt never hides a fault from the operator
    always_comb begin
        red_pat = fli_pkg::PAT_OFF;
        if (st_ff.err_stat[fli_pkg::ERR_PROC_WDG]) begin
            red_pat = fli_pkg::PAT_ON;
        end else if (st_ff.err_stat[fli_pkg::ERR_APP_WDG]) begin
            red_pat = fli_pkg::PAT_DOUBLE;
        end else if (st_ff.err_stat[fli_pkg::ERR_BOOT]) begin
            red_pat = fli_pkg::PAT_FLICKER;
        end else if (st_ff.err_stat[fli_pkg::ERR_CONFIG]) begin
            red_pat = fli_pkg::PAT_BLINK;
        end else if (st_ff.err_stat[fli_pkg::ERR_AUTO_CHANGE]) begin
            red_pat = fli_pkg::PAT_SINGLE;
        end
    end

    // ************************************************
    // bus decode and read word
    // ************************************************
    always_comb begin
        addr_take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
        rd_sel = reg_sel(ahb_req.haddr[7:0]);
        wr_sel = reg_sel(st_ff.wr_addr);
        rd_word = 32'h0000_0000;
        unique case (1'b1)
            rd_sel[0]: rd_word[fli_pkg::CTRL_W-1:0] = st_ff.ctrl;
            rd_sel[1]: rd_word[fli_pkg::ERR_N-1:0] = st_ff.err_stat;
            rd_sel[2]: rd_word[fli_pkg::ERR_N-1:0] = st_ff.err_mask;
            rd_sel[3]: begin
                rd_word[fli_pkg::LS_LINK_LSB +: 2] = st_ff.link_s2;
                rd_word[fli_pkg::LS_ACT_LSB +: 2] = st_ff.act_show;
                rd_word[fli_pkg::LS_LED_LSB +: 2] = st_ff.link_led;
                rd_word[fli_pkg::LS_RUN_BIT] = st_ff.run_led;
                rd_word[fli_pkg::LS_RED_BIT] = st_ff.red_on;
                rd_word[fli_pkg::LS_SDA_BIT] = st_ff.sda_s2;
                rd_word[fli_pkg::LS_PHASE_LSB +: fli_pkg::PHASE_W] =
                    st_ff.phase;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // ************************************************
    // error events
    // ************************************************
    // boot and autonomous-change faults only count while software has
    // flagged the change/error code in the application-layer status
    always_comb begin
        evt_rise = st_ff.evt_s2 & ~st_ff.evt_d;
        evt_set = evt_rise;
        evt_set[fli_pkg::ERR_BOOT] = evt_rise[fli_pkg::ERR_BOOT] &&
            change_err && (node == fli_pkg::NODE_INIT);
        evt_set[fli_pkg::ERR_AUTO_CHANGE] =
            evt_rise[fli_pkg::ERR_AUTO_CHANGE] && change_err;
        w1c = '0;
        if (st_ff.wr_pend && wr_sel[1]) begin
            w1c = ahb_req.hwdata[fli_pkg::ERR_N-1:0];
        end
    end

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        nxt_st = st_ff;

        // pins from outside the clock domain pass two flops first
        nxt_st.link_s1 = {outbound_port_link, inbound_port_link};
        nxt_st.link_s2 = st_ff.link_s1;
        nxt_st.act_s1 = {outbound_port_activity, inbound_port_activity};
        nxt_st.act_s2 = st_ff.act_s1;
        nxt_st.evt_s1[fli_pkg::ERR_PROC_WDG] =
            process_data_interface_wdg_timeout;
        nxt_st.evt_s1[fli_pkg::ERR_CONFIG] = config_error;
        nxt_st.evt_s1[fli_pkg::ERR_BOOT] = boot_error;
        nxt_st.evt_s1[fli_pkg::ERR_AUTO_CHANGE] = autonomous_change;
        nxt_st.evt_s1[fli_pkg::ERR_APP_WDG] = app_wdg_timeout;
        nxt_st.evt_s2 = st_ff.evt_s1;
        nxt_st.evt_d = st_ff.evt_s2;
        nxt_st.sda_s1 = err_sda_i;
        nxt_st.sda_s2 = st_ff.sda_s1;

        // one shared timebase keeps every lamp in step
        tick = st_ff.prescale ==
            fli_pkg::PRESCALE_W'(TICK_CYCLES - 1);
        if (tick) begin
            nxt_st.prescale = '0;
            if (st_ff.phase ==
                fli_pkg::PHASE_W'(fli_pkg::PHASE_PERIOD - 1)) begin
                nxt_st.phase = '0;
            end else begin
                nxt_st.phase = st_ff.phase + 1'b1;
            end
        end else begin
            nxt_st.prescale = st_ff.prescale + 1'b1;
        end

        // a single short frame still shows for at least one tick
        nxt_st.act_seen = st_ff.act_seen | st_ff.act_s2;
        if (tick) begin
            nxt_st.act_show = st_ff.act_seen | st_ff.act_s2;
            nxt_st.act_seen = '0;
        end
        for (int i = 0; i < 2; i++) begin
            nxt_st.link_led[i] = st_ff.link_s2[i] &&
                (!st_ff.act_show[i] || !st_ff.phase[0]);
        end

        nxt_st.run_led = run_lit;
        nxt_st.red_on = red_lit;

        // set wins over a write-one-to-clear in the same cycle
        nxt_st.err_stat = (st_ff.err_stat & ~w1c) | evt_set;
        nxt_st.irq = |(nxt_st.err_stat & st_ff.err_mask);

        // bus write data phase
        if (st_ff.wr_pend) begin
            if (wr_sel[0]) begin
                nxt_st.ctrl = ahb_req.hwdata[fli_pkg::CTRL_W-1:0] &
                    fli_pkg::CTRL_WMASK;
            end
            if (wr_sel[2]) begin
                nxt_st.err_mask = ahb_req.hwdata[fli_pkg::ERR_N-1:0];
            end
        end

        // bus address phase; narrow writes are ignored
        nxt_st.wr_pend = addr_take && ahb_req.hwrite &&
            (ahb_req.hsize == fli_pkg::HSIZE_WORD);
        nxt_st.wr_addr = ahb_req.haddr[7:0];
        if (addr_take && !ahb_req.hwrite) begin
            nxt_st.hrdata = rd_word;
        end else begin
            nxt_st.hrdata = 32'h0000_0000;
        end
    end

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.ctrl <= fli_pkg::CTRL_RESET;
            st_ff.err_stat <= fli_pkg::ERR_RESET;
            st_ff.err_mask <= fli_pkg::ERR_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    // the red lamp sinks through the i2c data line: pulling it low
    // lights it, so any real i2c traffic on that line shares the lamp
    assign err_sda_o = 1'b0;
    assign err_sda_oe_n = ~st_ff.red_on;
    assign inbound_port_link_led = st_ff.link_led[0];
    assign outbound_port_link_led = st_ff.link_led[1];
    assign run_led = st_ff.run_led;
    assign irq = st_ff.irq;
    assign ahb_rsp.hrdata = st_ff.hrdata;
    assign ahb_rsp.hreadyout = 1'b1;
    assign ahb_rsp.hresp = 1'b0;

endmodule

`default_nettype wire

// *** tb/fli_indicator_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

module fli_indicator_asserts #(
    parameter int TICK_CYCLES = fli_pkg::TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire fli_pkg::fli_ahb_req_t ahb_req,
    input wire fli_pkg::fli_ahb_rsp_t ahb_rsp,
    input wire logic inbound_port_link,
    input wire logic inbound_port_activity,
    input wire logic outbound_port_link,
    input wire logic outbound_port_activity,
    input wire logic process_data_interface_wdg_timeout,
    input wire logic config_error,
    input wire logic boot_error,
    input wire logic autonomous_change,
    input wire logic app_wdg_timeout,
    input wire logic inbound_port_link_led,
    input wire logic outbound_port_link_led,
    input wire logic run_led,
    input wire logic err_sda_i,
    input wire logic err_sda_o,
    input wire logic err_sda_oe_n,
    input wire logic irq
);
    // sync, latched activity and led register give some slack
    localparam int LIT_MAX = 3 * TICK_CYCLES + 4;
    int on_cnt;
    int fl_cnt;
    logic rd_take;

    assign rd_take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready
        && !ahb_req.hwrite;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            on_cnt <= 0;
            fl_cnt <= 0;
        end else begin
            on_cnt <= (inbound_port_link && !inbound_port_activity)
                ? on_cnt + 1 : 0;
            fl_cnt <= (inbound_port_activity && inbound_port_link_led)
                ? fl_cnt + 1 : 0;
        end
    end

    // ********
    // checks
    // ********
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_ready; ahb_rsp.hreadyout && !ahb_rsp.hresp; endproperty
    a_ready: assert property (p_ready) else $error("bus stalled");
    property p_rd_idle; !rd_take |=> ahb_rsp.hrdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stale read data");
    property p_unmap;
        rd_take && ahb_req.haddr[7:0] > 8'h0c |=> ahb_rsp.hrdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
    property p_rst_out;
        $fell(rst) |-> !inbound_port_link_led && !outbound_port_link_led
            && !run_led && err_sda_oe_n && !irq;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs after reset");
    property p_in_off; !inbound_port_link [*4] |-> !inbound_port_link_led;
    endproperty
    a_in_off: assert property (p_in_off) else $error("in led lit");
    property p_out_off; !outbound_port_link [*4] |-> !outbound_port_link_led;
    endproperty
    a_out_off: assert property (p_out_off) else $error("out led lit");
    property p_in_on; on_cnt > LIT_MAX |-> inbound_port_link_led; endproperty
    a_in_on: assert property (p_in_on) else $error("in led dark");
    property p_in_flick; fl_cnt <= LIT_MAX; endproperty
    a_in_flick: assert property (p_in_flick) else $error("no flicker");
    property p_proc_red;
        $rose(process_data_interface_wdg_timeout)
            |-> ##[1:6] !err_sda_oe_n [*8];
    endproperty
    a_proc_red: assert property (p_proc_red) else $error("red off");
    property p_sda_low; !err_sda_oe_n |-> !err_sda_o; endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda high");

    c_red: cover property (!err_sda_oe_n);
    c_irq: cover property ($rose(irq));
    c_run: cover property ($rose(run_led));
endmodule

bind fli_indicator fli_indicator_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .mclk(mclk), .rst(rst), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
    .inbound_port_link(inbound_port_link),
    .inbound_port_activity(inbound_port_activity),
    .outbound_port_link(outbound_port_link),
    .outbound_port_activity(outbound_port_activity),
    .process_data_interface_wdg_timeout(process_data_interface_wdg_timeout),
    .config_error(config_error), .boot_error(boot_error),
    .autonomous_change(autonomous_change), .app_wdg_timeout(app_wdg_timeout),
    .inbound_port_link_led(inbound_port_link_led),
    .outbound_port_link_led(outbound_port_link_led), .run_led(run_led),
    .err_sda_i(err_sda_i), .err_sda_o(err_sda_o),
    .err_sda_oe_n(err_sda_oe_n), .irq(irq)
);

`default_nettype wire

// *** tb/fli_led_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module fli_led_model (
    input wire logic mclk,
    input wire logic clr,
    input wire logic in_led,
    input wire logic out_led,
    input wire logic run_led,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    output logic sda_line,
    output logic [3:0][9:0] lit_cnt,
    output logic [3:0][9:0] rise_cnt
);
    logic [3:0] lit;
    logic [3:0] prev = 4'h0;

    // pull-up holds the line high whenever the block lets go of it
    assign sda_line = sda_oe_n ? 1'b1 : sda_o;
    assign lit = {!sda_line, run_led, out_led, in_led};

    // counts lit cycles and turn-ons over a window opened by clr
    always @(posedge mclk) begin
        prev <= lit;
        for (int i = 0; i < 4; i++) begin
            if (clr) begin
                lit_cnt[i] <= 10'h0;
                rise_cnt[i] <= 10'h0;
            end else begin
                lit_cnt[i] <= lit_cnt[i] + 10'(lit[i]);
                rise_cnt[i] <= rise_cnt[i] + 10'(lit[i] && !prev[i]);
            end
        end
    end
endmodule

`default_nettype wire

// *** tb/fli_indicator_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module fli_indicator_tb;
    localparam int TICK = 4;
    localparam int W = fli_pkg::PHASE_PERIOD * TICK;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] lnk = 4'h0;
    logic [4:0] evt = 5'h0;
    logic clr = 1'b0;
    int failures = 0;
    int total_checks = 0;
    fli_pkg::fli_ahb_req_t req;
    fli_pkg::fli_ahb_rsp_t rsp;
    wire logic led_in, led_out, led_run, sda_o, sda_oe_n, sda_line, irq;
    wire logic [3:0][9:0] lit_cnt;
    wire logic [3:0][9:0] rise_cnt;
    // ********
    // expected {lit cycles, turn-ons} over one full phase period
    // ********
    logic [31:0] rc [8] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h5,
        32'h6, 32'h11};
    logic [19:0] rx [8] = '{{10'hc0, 10'h30}, 20'h0, {10'hc0, 10'h0c},
        {10'hc0, 10'h30}, {10'h40, 10'h4}, {10'h180, 10'h0}, 20'h0,
        {10'hc0, 10'h30}};
    logic [3:0] lv [3] = '{4'h1, 4'h7, 4'he};
    logic [39:0] lx [3] = '{{10'h180, 30'h0}, {10'hc0, 10'h30, 10'h180,
        10'h0}, {20'h0, 10'hc0, 10'h30}};
    logic [31:0] ec [5] = '{32'h1, 32'h10, 32'h4, 32'h2, 32'h8};
    logic [19:0] ex [5] = '{{10'h60, 10'h6}, {10'hc0, 10'h30},
        {10'hc0, 10'h0c}, {10'h40, 10'h4}, 20'h0};
    logic [4:0] ei = 5'h07;

    assign req = {hsel, haddr, htrans, hwrite, fli_pkg::HSIZE_WORD, hwdata,
        rsp.hreadyout};

    fli_indicator #(.TICK_CYCLES(TICK)) DUT (
        .mclk(mclk), .rst(rst), .ahb_req(req), .ahb_rsp(rsp),
        .inbound_port_link(lnk[0]), .inbound_port_activity(lnk[1]),
        .outbound_port_link(lnk[2]), .outbound_port_activity(lnk[3]),
        .process_data_interface_wdg_timeout(evt[0]), .config_error(evt[1]),
        .boot_error(evt[2]), .autonomous_change(evt[3]),
        .app_wdg_timeout(evt[4]), .inbound_port_link_led(led_in),
        .outbound_port_link_led(led_out), .run_led(led_run),
        .err_sda_i(sda_line), .err_sda_o(sda_o), .err_sda_oe_n(sda_oe_n),
        .irq(irq)
    );

    fli_led_model u_leds (
        .mclk(mclk), .clr(clr), .in_led(led_in), .out_led(led_out),
        .run_led(led_run), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .sda_line(sda_line), .lit_cnt(lit_cnt), .rise_cnt(rise_cnt)
    );

    always #2.5 mclk = ~mclk;

    task automatic end_sim();
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // entered just after a rising edge; holds each phase until hready
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge mclk); while (rsp.hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (rsp.hreadyout !== 1'b1);
        q = rsp.hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk($sformatf("reg%h", a), e, q);
    endtask

    // settle, then count one full phase period at the led side
    task automatic meas(input int i, input logic [19:0] e);
        repeat (16) @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (W) @(posedge mclk);
        #1;
        chk($sformatf("lit%0d", i), 32'(e[19:10]), 32'(lit_cnt[i]));
        chk($sformatf("rise%0d", i), 32'(e[9:0]), 32'(rise_cnt[i]));
        @(posedge mclk);
    endtask

    task automatic pulse(input logic [4:0] v);
        evt <= v;
        repeat (2) @(posedge mclk);
        evt <= 5'h0;
        repeat (6) @(posedge mclk);
    endtask

    initial begin
        #200000;
        failures++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("irq", 32'h0, 32'(irq));
        rd(fli_pkg::OFF_CTRL, 32'h0);
        rd(fli_pkg::OFF_ERR_STATUS, 32'h0);
        rd(fli_pkg::OFF_ERR_MASK, 32'h0);
        rd(8'h10, 32'h0);
        wr(fli_pkg::OFF_CTRL, 32'hffffffff);
        rd(fli_pkg::OFF_CTRL, 32'(fli_pkg::CTRL_WMASK));
        for (int n = 0; n < 8; n++) begin
            wr(fli_pkg::OFF_CTRL, rc[n]);
            meas(2, rx[n]);
        end
        for (int k = 0; k < 3; k++) begin
            lnk <= lv[k];
            meas(0, lx[k][39:20]);
            meas(1, lx[k][19:0]);
        end
        // change flag still clear, so this event must not latch
        pulse(5'h08);
        rd(fli_pkg::OFF_ERR_STATUS, 32'h0);
        wr(fli_pkg::OFF_CTRL, 32'h0101);
        pulse(5'h1f);
        rd(fli_pkg::OFF_ERR_STATUS, 32'h1f);
        chk("irq", 32'h0, 32'(irq));
        wr(fli_pkg::OFF_ERR_MASK, 32'h2);
        meas(3, {10'h180, 10'h0});
        chk("irq", 32'h1, 32'(irq));
        for (int k = 0; k < 5; k++) begin
            wr(fli_pkg::OFF_ERR_STATUS, ec[k]);
            meas(3, ex[k]);
            chk("irq", 32'(ei[k]), 32'(irq));
        end
        pulse(5'h02);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        // first cycle out of reset: phase 0, booting flicker lit
        rd(fli_pkg::OFF_LINK_STATUS, 32'h40);
        rd(fli_pkg::OFF_ERR_STATUS, 32'h0);
        rd(fli_pkg::OFF_CTRL, 32'h0);
        end_sim();
    end
endmodule

`default_nettype wire
